// ===== src/cixs_core.sv
// Function
// - Interrupt entry pushes only the return PC, never W or status.
// - Jump sets PC 10..0 from the immediate and PC 12..11 from latch 4..3.
// - Increment-skip adds one to the file, routes by d, leaves flags alone.
// - A zero increment-skip result drops the fetched next word for a NOP.
// - Increment adds one to the file, routes by d and updates Z.
// - Literal OR into W updates Z in one cycle.
// - Literal XOR into W updates Z in one cycle.
// - Nibble swap exchanges file nibbles, routes by d, touches no flag.
// - Direction load copies W into direction register 5 to 7, no flags.
// - Addresses 0x70 to 0x7F map to one location whatever the bank bit.
`timescale 1ns/100ps
`default_nettype none
`include "cixs_params.svh"
module cixs_core
  import cixs_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire cixs_pkg::cixs_word_t i_instr,
  input  wire logic              i_irq,
  input  wire logic [4:0]        i_upper_pc_latch,
  input  wire logic              i_bank_select_bit,
  output logic                   o_fetch_ready,
  output cixs_pkg::cixs_pc_t     o_pc,
  output cixs_pkg::cixs_pc_t     o_stack_push_pc,
  output logic                   o_stack_push,
  output cixs_pkg::cixs_byte_t   o_w,
  output logic                   o_zero_flag,
  output cixs_pkg::cixs_byte_t   o_dir_5,
  output cixs_pkg::cixs_byte_t   o_dir_6,
  output cixs_pkg::cixs_byte_t   o_dir_7
);
  import cixs_pkg::*;

  // Bank bit forms address bit 7, except in the shared block
  function automatic logic [7:0] map_addr(input logic bank,
                                          input logic [6:0] f);
    if ((f & `CIXS_SHARED_MASK) == `CIXS_SHARED_BASE) begin
      map_addr = {1'b0, f};
    end else begin
      map_addr = {bank, f};
    end
  endfunction

  cixs_ram_if  ram ();
  cixs_ram u_ram (
    .i_clk_sys (i_clk_sys),
    .bus       (ram.mem)
  );

  cixs_state_t state;
  cixs_state_t next_state;
  cixs_word_t  ir;
  logic        ir_valid;
  cixs_byte_t  dir [5:7];

  // Decode, registered word held one cycle while file data is read
  logic        is_jump, is_incskip, is_inc, is_orlit, is_xorlit;
  logic        is_swap, is_xorf, is_dir;
  logic        dest_f;
  cixs_byte_t  fval, result;
  logic        wr_w, wr_f, wr_z, skip;

  assign is_jump    = ir_valid && ir[13:11] == `CIXS_OP_JUMP;
  assign is_incskip = ir_valid && ir[13:8] == `CIXS_OP_INCSKIP;
  assign is_inc     = ir_valid && ir[13:8] == `CIXS_OP_INC;
  assign is_orlit   = ir_valid && ir[13:8] == `CIXS_OP_ORLIT;
  assign is_xorlit  = ir_valid && ir[13:8] == `CIXS_OP_XORLIT;
  assign is_swap    = ir_valid && ir[13:8] == `CIXS_OP_SWAP;
  assign is_xorf    = ir_valid && ir[13:8] == `CIXS_OP_XORF;
  assign is_dir     = ir_valid && ir[13:3] == `CIXS_DIRLOAD_HI
                      && ir[2:0] >= `CIXS_DIR_FIRST;
  assign dest_f     = ir[7];
  assign fval       = ram.rdata;

  // Operand read issued on fetch so data is ready when executing
  assign ram.raddr = map_addr(i_bank_select_bit, i_instr[6:0]);
  assign ram.waddr = map_addr(i_bank_select_bit, ir[6:0]);
  assign ram.wdata = result;
  assign ram.we    = wr_f && state == CIXS_ST_RUN;

  always_comb begin
    result = fval;
    wr_w   = 1'b0;
    wr_f   = 1'b0;
    wr_z   = 1'b0;
    skip   = 1'b0;
    unique case (1'b1)
      is_incskip: begin
        result = fval + 8'h01;
        wr_w   = !dest_f;
        wr_f   = dest_f;
        skip   = result == 8'h00;
      end
      is_inc: begin
        result = fval + 8'h01;
        wr_w   = !dest_f;
        wr_f   = dest_f;
        wr_z   = 1'b1;
      end
      is_orlit: begin
        result = o_w | ir[7:0];
        wr_w   = 1'b1;
        wr_z   = 1'b1;
      end
      is_xorlit: begin
        result = o_w ^ ir[7:0];
        wr_w   = 1'b1;
        wr_z   = 1'b1;
      end
      is_swap: begin
        result = {fval[3:0], fval[7:4]};
        wr_w   = !dest_f;
        wr_f   = dest_f;
      end
      is_xorf: begin
        result = o_w ^ fval;
        wr_w   = !dest_f;
        wr_f   = dest_f;
        wr_z   = 1'b1;
      end
      default: begin
        result = fval;
      end
    endcase
  end

  always_comb begin
    next_state = CIXS_ST_RUN;
    if (state == CIXS_ST_RUN && (is_jump || skip)) begin
      next_state = CIXS_ST_FLUSH;
    end
  end

  assign o_fetch_ready = 1'b1;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= CIXS_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Flushed slot executes as a NOP
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ir       <= `CIXS_NOP;
      ir_valid <= 1'b0;
    end else if (next_state == CIXS_ST_FLUSH || i_irq) begin
      ir       <= `CIXS_NOP;
      ir_valid <= 1'b0;
    end else begin
      ir       <= i_instr;
      ir_valid <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pc <= `CIXS_RST_PC;
    end else if (i_irq && state == CIXS_ST_RUN && !is_jump && !skip) begin
      o_pc <= `CIXS_IRQ_VECTOR;
    end else if (is_jump && state == CIXS_ST_RUN) begin
      o_pc <= {i_upper_pc_latch[`CIXS_LATCH_JUMP_MSB:`CIXS_LATCH_JUMP_LSB],
               ir[`CIXS_PC_LOW_MSB:0]};
    end else begin
      o_pc <= o_pc + 13'h0001;
    end
  end

  // Only the return address goes to the stack; W and Z are not saved
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_stack_push    <= 1'b0;
      o_stack_push_pc <= `CIXS_RST_PC;
    end else begin
      o_stack_push    <= i_irq && state == CIXS_ST_RUN && !is_jump && !skip;
      o_stack_push_pc <= o_pc;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_w <= 8'h00;
    end else if (wr_w && state == CIXS_ST_RUN) begin
      o_w <= result;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_zero_flag <= 1'b0;
    end else if (wr_z && state == CIXS_ST_RUN) begin
      o_zero_flag <= result == 8'h00;
    end
  end

  genvar g;
  generate
    for (g = 5; g <= 7; g++) begin : g_dir
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          dir[g] <= `CIXS_RST_DIR;
        end else if (is_dir && ir[2:0] == 3'(g)) begin
          dir[g] <= o_w;
        end
      end
    end
  endgenerate
  assign o_dir_5 = dir[5];
  assign o_dir_6 = dir[6];
  assign o_dir_7 = dir[7];

  a_jump_target: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    is_jump && state == CIXS_ST_RUN
    |=> o_pc[`CIXS_PC_LOW_MSB:0] == $past(ir[`CIXS_PC_LOW_MSB:0])
        && o_pc[`CIXS_PC_UPPER_MSB:`CIXS_PC_LOW_MSB + 1]
        == $past(i_upper_pc_latch[`CIXS_LATCH_JUMP_MSB:`CIXS_LATCH_JUMP_LSB]))
    else $error("jump target wrong");
  a_jump_flush: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    is_jump && state == CIXS_ST_RUN |=> !ir_valid)
    else $error("jump did not flush");
  a_skip_flush: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    skip && state == CIXS_ST_RUN |=> state == CIXS_ST_FLUSH && !ir_valid)
    else $error("skip did not flush");
  a_skip_flags: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    is_incskip |=> $stable(o_zero_flag))
    else $error("skip changed zero flag");
  a_swap_flags: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    is_swap |=> $stable(o_zero_flag))
    else $error("swap changed zero flag");
  a_orlit_zero: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    is_orlit && state == CIXS_ST_RUN
    |=> o_w == ($past(o_w) | $past(ir[7:0]))
        && o_zero_flag == (o_w == 8'h00))
    else $error("or literal result wrong");
  a_xorlit_zero: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    is_xorlit && state == CIXS_ST_RUN
    |=> o_w == ($past(o_w) ^ $past(ir[7:0]))
        && o_zero_flag == (o_w == 8'h00))
    else $error("xor literal result wrong");
  // The word in flight at entry is dropped, so the slot after it is a NOP
  a_irq_keep_w: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    o_stack_push |=> $stable(o_w) && $stable(o_zero_flag))
    else $error("interrupt touched W or Z");
  a_shared_map: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_instr[6:4] == 3'h7 |-> ram.raddr[7] == 1'b0)
    else $error("shared block banked");
  a_bank_map: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_instr[6:4] != 3'h7 |-> ram.raddr[7] == i_bank_select_bit)
    else $error("bank bit not applied");
endmodule
`default_nettype wire

// ===== src/cixs_params.svh
`ifndef CIXS_PARAMS_SVH
`define CIXS_PARAMS_SVH
`define CIXS_PC_LOW_MSB      10
`define CIXS_PC_UPPER_MSB    12
`define CIXS_LATCH_JUMP_LSB  3
`define CIXS_LATCH_JUMP_MSB  4
`define CIXS_OP_JUMP         3'b101
`define CIXS_OP_INCSKIP      6'b00_1111
`define CIXS_OP_INC          6'b00_1010
`define CIXS_OP_ORLIT        6'b11_1000
`define CIXS_OP_XORLIT       6'b11_1010
`define CIXS_OP_SWAP         6'b00_1110
`define CIXS_OP_XORF         6'b00_0110
`define CIXS_DIRLOAD_HI      11'h00C
`define CIXS_DIR_FIRST       3'h5
`define CIXS_DIR_LAST        3'h7
`define CIXS_SHARED_BASE     7'h70
`define CIXS_SHARED_MASK     7'h70
`define CIXS_NOP             14'h0000
`define CIXS_RST_LATCH       5'h00
`define CIXS_RST_DIR         8'hFF
`define CIXS_RST_PC          13'h0000
`define CIXS_IRQ_VECTOR      13'h0004
`endif

// ===== src/cixs_pkg.sv
package cixs_pkg;
  typedef logic [12:0] cixs_pc_t;
  typedef logic [7:0]  cixs_byte_t;
  typedef logic [13:0] cixs_word_t;
  typedef enum logic [1:0] {
    CIXS_ST_RUN   = 2'b01,
    CIXS_ST_FLUSH = 2'b10
  } cixs_state_t;
endpackage

// ===== src/cixs_ram_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cixs_ram_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface
`default_nettype wire

// ===== src/cixs_ram.sv
`timescale 1ns/100ps
`default_nettype none
module cixs_ram (
  input  wire logic i_clk_sys,
  cixs_ram_if.mem   bus
);
  logic [7:0] mem [0:255];
  // No reset on storage, it is plain RAM; read data is registered
  always_ff @(posedge i_clk_sys) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end
  // Write-first on an address hit: back-to-back file ops see fresh data
  always_ff @(posedge i_clk_sys) begin
    if (bus.we && bus.waddr == bus.raddr) begin
      bus.rdata <= bus.wdata;
    end else begin
      bus.rdata <= mem[bus.raddr];
    end
  end
endmodule
`default_nettype wire

// ===== dv/cixs_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module cixs_prog_mem
  import cixs_pkg::*;
(
  input  wire logic            i_clk_sys,
  output cixs_pkg::cixs_word_t o_instr
);
  cixs_word_t q[$];
  initial o_instr = 14'h0000;
  // Empty slots read as NOP so no stale word is executed twice
  always @(posedge i_clk_sys) begin
    if (q.size() != 0) begin
      o_instr <= q.pop_front();
    end else begin
      o_instr <= 14'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== dv/cpu_instruction_execute_subset_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cixs_params.svh"
module cpu_instruction_execute_subset_tb;
  import cixs_pkg::*;
  logic       i_clk_sys = 1'b0;
  logic       i_rst     = 1'b1;
  logic       irq       = 1'b0;
  logic       bsb       = 1'b0;
  logic [4:0] latch     = 5'h00;
  logic       rdy, push, z, mz, msk;
  cixs_word_t instr;
  cixs_pc_t   pc, spc;
  cixs_byte_t w, d5, d6, d7, mw;
  cixs_byte_t ram [256];
  cixs_byte_t md [8];
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cyc = 0;

  cixs_prog_mem pm_u (.i_clk_sys(i_clk_sys), .o_instr(instr));
  cixs_core dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr(instr),
    .i_irq(irq), .i_upper_pc_latch(latch), .i_bank_select_bit(bsb),
    .o_fetch_ready(rdy), .o_pc(pc), .o_stack_push_pc(spc),
    .o_stack_push(push), .o_w(w), .o_zero_flag(z), .o_dir_5(d5),
    .o_dir_6(d6), .o_dir_7(d7));

  always #10 i_clk_sys = ~i_clk_sys;
  // Whole run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(string nm, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk();
    cmp("w", {8'h00, mw}, {8'h00, w});
    cmp("z", {15'h0000, mz}, {15'h0000, z});
    cmp("dir5", {8'h00, md[5]}, {8'h00, d5});
    cmp("dir6", {8'h00, md[6]}, {8'h00, d6});
    cmp("dir7", {8'h00, md[7]}, {8'h00, d7});
  endtask

  // Shared block maps to bank 0 here; only its bank independence shows
  task automatic model(cixs_word_t iw);
    logic [7:0] a, r;
    a = (iw[6:4] == 3'h7) ? {1'b0, iw[6:0]} : {bsb, iw[6:0]};
    msk = 1'b0;
    case (iw[13:8])
      6'h3a: begin mw = mw ^ iw[7:0]; mz = (mw == 8'h00); end
      6'h38: begin mw = mw | iw[7:0]; mz = (mw == 8'h00); end
      6'h0a, 6'h0f, 6'h0e, 6'h06: begin
        if (iw[11:8] == 4'he) r = {ram[a][3:0], ram[a][7:4]};
        else if (iw[11:8] == 4'h6) r = mw ^ ram[a];
        else r = ram[a] + 8'h01;
        if (iw[7]) ram[a] = r;
        else mw = r;
        if (iw[11:8] == 4'ha || iw[11:8] == 4'h6) mz = (r == 8'h00);
        if (iw[11:8] == 4'hf) msk = (r == 8'h00);
      end
      default: begin
        if (iw[13:3] == 11'h00c && iw[2:0] >= 3'h5) md[iw[2:0]] = mw;
      end
    endcase
  endtask

  task automatic ex(cixs_word_t iw);
    pm_u.q.push_back(iw);
    model(iw);
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk();
  endtask

  task automatic t_literals();
    ex(14'h3aff); ex(14'h3800); ex(14'h38a5); ex(14'h3aff);
    ex(14'h3a5a); ex(14'h3800); ex(14'h3a00);
  endtask

  task automatic t_file_ops();
    ex(14'h3a3d); ex(14'h06a0); ex(14'h0e20); ex(14'h0ea0);
    ex(14'h3ac3); ex(14'h06a1); ex(14'h0a21); ex(14'h0aa1);
    ex(14'h3aff); ex(14'h06a2); ex(14'h0aa2); ex(14'h0622);
  endtask

  // Increment-skip followed at once by a literal word, which only runs
  // when the increment result is not zero
  task automatic skip_pair(cixs_word_t iw);
    pm_u.q.push_back(iw);
    pm_u.q.push_back(14'h3a55);
    model(iw);
    if (!msk) model(14'h3a55);
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk();
  endtask

  task automatic t_skip();
    ex(14'h3afc); ex(14'h06a3);
    skip_pair(14'h0fa3);
    skip_pair(14'h0f23);
    ex(14'h3aab); ex(14'h06a4);
    skip_pair(14'h0f24);
  endtask

  task automatic t_jump();
    @(posedge i_clk_sys) latch <= 5'h15;
    @(negedge i_clk_sys);
    pm_u.q.push_back({3'b101, 11'h5a5});
    pm_u.q.push_back(14'h3a0f);
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    cmp("pc", {3'b000, 2'b10, 11'h5a5}, {3'b000, pc});
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk();
  endtask

  task automatic t_dir_shared();
    ex(14'h3a96); ex(14'h0065); ex(14'h0064);
    ex(14'h3a5a); ex(14'h0066); ex(14'h0067);
    ex(14'h06f0); ex(14'h06a0);
    @(posedge i_clk_sys) bsb <= 1'b1;
    @(negedge i_clk_sys);
    ex(14'h0670); ex(14'h0620); ex(14'h06a0);
  endtask

  task automatic t_irq();
    cixs_pc_t ret;
    ex(14'h3a42);
    @(posedge i_clk_sys) irq <= 1'b1;
    @(negedge i_clk_sys) ret = pc;
    @(posedge i_clk_sys) irq <= 1'b0;
    @(negedge i_clk_sys);
    cmp("push", 16'h0001, {15'h0000, push});
    cmp("push_pc", {3'b000, ret}, {3'b000, spc});
    cmp("pc", {3'b000, `CIXS_IRQ_VECTOR}, {3'b000, pc});
    chk();
    @(negedge i_clk_sys);
    cmp("push", 16'h0000, {15'h0000, push});
    chk();
  endtask

  initial begin
    for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    for (int i = 0; i < 8; i++) md[i] = 8'hff;
    mw = 8'h00;
    mz = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    chk();
    cmp("ready", 16'h0001, {15'h0000, rdy});
    t_literals();
    t_file_ops();
    t_skip();
    t_jump();
    t_dir_shared();
    t_irq();
    complete_run();
  end
endmodule
`default_nettype wire
